//--- inc/ahs_pkg.sv
// Register map, field layout and timing constants of the trigger sequencer
package ahs_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_MODE0  = 8'h00;
  localparam logic [7:0] OFF_MODE1  = 8'h04;
  localparam logic [7:0] OFF_MODE2  = 8'h08;
  localparam logic [7:0] OFF_CHSEL  = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_ULIM   = 8'h14;
  localparam logic [7:0] OFF_LLIM   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int M0_EN      = 0;
  localparam int M0_SCAN    = 1;
  localparam int M0_ONESHOT = 2;
  localparam int M0_START   = 7;
  localparam int M2_SNZ     = 2;
  localparam int M2_RCK     = 3;
  localparam int ST_STATE   = 0;
  localparam int ST_SLOT    = 2;
  localparam int ST_CLKREQ  = 4;
  localparam int ST_WOKE    = 5;

  // ==========================================================================
  // Widths, trigger source codes and reset values
  localparam int CH_W  = 5;
  localparam int RES_W = 10;
  localparam int LIM_W = 8;
  localparam int MODE_W = 8;
  localparam logic [1:0] TRG_EVENT    = 2'h1;
  localparam logic [1:0] TRG_CALENDAR = 2'h2;
  localparam logic [1:0] TRG_INTERVAL = 2'h3;
  localparam logic [7:0] MODE1_RST = 8'h00;
  localparam logic [7:0] ULIM_RST  = 8'hFF;
  localparam logic [7:0] LLIM_RST  = 8'h00;

  // ==========================================================================
  // Power stabilization wait, rounded up to whole clock cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAB_TIME_NS  = 1000;
  localparam int STAB_CYC = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_WAIT = 2'b01,
    ST_STAB = 2'b11,
    ST_CONV = 2'b10
  } ahs_state_e;

endpackage

//--- hdl/ahs_sync.sv
// Three-stage synchroniser whose output follows once stages two and three agree
module ahs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] f1_q;
  logic [W-1:0] f2_q;
  logic [W-1:0] f3_q;
  logic [W-1:0] out_q;

  // Per bit: take the value when both stages agree, else hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f1_q  <= '0;
      f2_q  <= '0;
      f3_q  <= '0;
      out_q <= '0;
    end else begin
      f1_q  <= async_in;
      f2_q  <= f1_q;
      f3_q  <= f2_q;
      out_q <= (f2_q & f3_q) | (out_q & (f2_q | f3_q));
    end
  end

  assign sync_out = out_q;

endmodule

//--- hdl/ahs_ctrl.sv
// Hardware-trigger wait scan sequencer with low-power low_power_autonomous_mode and APB registers
//
// The APB register port and the placing of the registers were decided locally.

// Notes on behaviour
// RULE1 - Enable written 1 while stopped enters trigger standby, no conversion yet.
// RULE2 - Trigger in standby sets start bit and begins the four-channel scan.
// RULE3 - Scan slots convert in order from the first to the fourth.
// RULE4 - Each finished channel stores its result and pulses the end interrupt.
// RULE5 - Sequential form starts the next pass itself after the fourth channel.
// RULE6 - One-shot form clears start bit after the pass and returns to standby.
// RULE7 - Trigger during a scan aborts it and restarts from the first channel.
// RULE8 - Any channel register write during conversion aborts and restarts.
// RULE9 - Start bit written 1 during conversion aborts and restarts.
// RULE10 - Start bit cleared during conversion aborts and returns to standby.
// RULE11 - With enable 0 every trigger is ignored.
// RULE12 - Range-rejected results are neither stored nor interrupt.
// RULE13 - Low_power_autonomous_mode converts from stop mode, one-shot forms only.
// RULE14 - Software enables low_power_autonomous_mode only on the fast on-chip oscillator.
// RULE15 - Software sets up, sets low_power_autonomous_mode-wait bit, then the enable bit.
// RULE16 - Software loads mode register 1 with one of three low_power_autonomous_mode values.
// RULE17 - Low_power_autonomous_mode trigger requests oscillator clock and counts stabilization wait.
// RULE18 - Trigger source chosen in mode register 1 among three sources.
// RULE19 - Select-mode low_power_autonomous_mode with passing result interrupts and wakes.
// RULE20 - Scan low_power_autonomous_mode with any interrupt keeps clock request high, wakes.
// RULE21 - No interrupt in low_power_autonomous_mode pass drops clock request until next trigger.
// RULE22 - After wake software clears low_power_autonomous_mode-wait; until then triggers are ignored.
module ahs_ctrl
  import ahs_pkg::*;
#(
  parameter int SCAN_N      = 4,
  parameter int STAB_CYCLES = STAB_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             trig_event_in,
  input  wire logic             trig_calendar_in,
  input  wire logic             trig_interval_in,
  input  wire logic             stop_mode,
  output logic                  conv_start,
  output logic                  conv_abort,
  output logic      [CH_W-1:0]  conv_channel,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_data,
  output logic                  conversion_end_irq,
  output logic                  osc_clk_req,
  output logic                  low_power_autonomous_mode_wakeup
);

  localparam int SLOT_W = $clog2(SCAN_N);
  localparam int CNT_W  = 12;

  initial begin
    // Status register holds only two slot bits
    if (SCAN_N < 2 || SCAN_N > 4 || SCAN_N != (1 << SLOT_W))
      $error("SCAN_N must be 2 or 4");
    if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << CNT_W))
      $error("STAB_CYCLES out of range");
  end

  // ==========================================================================
  // State
  ahs_state_e          state_q, state_d;
  logic                enable_q;
  logic                scan_q;
  logic                oneshot_q;
  logic                start_q, start_d;
  logic [MODE_W-1:0]   mode1_q;
  logic                snz_wait_q;
  logic                rck_q;
  logic [CH_W-1:0]     chsel_q;
  logic [LIM_W-1:0]    ulim_q;
  logic [LIM_W-1:0]    llim_q;
  logic [RES_W-1:0]    result_q;
  logic [SLOT_W-1:0]   slot_q, slot_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic                clkreq_q, clkreq_d;
  logic                snz_act_q, snz_act_d;
  logic                hit_q, hit_d;
  logic                woke_q, woke_d;
  logic                cstart_q, cstart_d;
  logic                cabort_q, cabort_d;
  logic [CH_W-1:0]     chan_q;
  logic                irq_q;
  logic                wake_q, wake_d;
  logic [31:0]         prdata_q;

  // ==========================================================================
  // APB decode; zero wait states, read data captured in setup phase
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire sel_m0  = (paddr == OFF_MODE0);
  wire sel_m1  = (paddr == OFF_MODE1);
  wire sel_m2  = (paddr == OFF_MODE2);
  wire sel_ch  = (paddr == OFF_CHSEL);
  wire sel_res = (paddr == OFF_RESULT);
  wire sel_ul  = (paddr == OFF_ULIM);
  wire sel_ll  = (paddr == OFF_LLIM);
  wire sel_st  = (paddr == OFF_STATUS);
  wire mapped  = sel_m0 | sel_m1 | sel_m2 | sel_ch | sel_res | sel_ul |
                 sel_ll | sel_st;

  wire wr_m0    = wr & sel_m0;
  wire wr_ch    = wr & sel_ch;
  wire wr_m2    = wr & sel_m2;
  wire new_en   = pwdata[M0_EN];
  wire start1   = wr_m0 & pwdata[M0_START];
  wire start0   = wr_m0 & ~pwdata[M0_START];
  wire en_now   = wr_m0 ? new_en : enable_q;
  wire oneshot_now = wr_m0 ? pwdata[M0_ONESHOT] : oneshot_q;
  wire scan_now = wr_m0 ? pwdata[M0_SCAN] : scan_q;
  wire snz_now  = wr_m2 ? pwdata[M2_SNZ] : snz_wait_q;
  wire [CH_W-1:0] base_now = wr_ch ? pwdata[CH_W-1:0] : chsel_q;

  wire [31:0] status_w = {26'h0, woke_q, clkreq_q, 2'(slot_q), state_q};
  wire [31:0] rd_word =
    sel_m0  ? {24'h0, start_q, 4'h0, oneshot_q, scan_q, enable_q} :
    sel_m1  ? {24'h0, mode1_q} :
    sel_m2  ? {28'h0, rck_q, snz_wait_q, 2'h0} :
    sel_ch  ? {27'h0, chsel_q} :
    sel_res ? {22'h0, result_q} :
    sel_ul  ? {24'h0, ulim_q} :
    sel_ll  ? {24'h0, llim_q} :
    sel_st  ? status_w : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_q;

  // ==========================================================================
  // Trigger select and gating
  logic [2:0] trig_sync;
  logic [2:0] trig_prev_q;

  ahs_sync #(.W(3)) u_trig_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({trig_interval_in, trig_calendar_in, trig_event_in}),
    .sync_out (trig_sync)
  );

  wire [2:0] trig_edge = trig_sync & ~trig_prev_q;
  wire [1:0] trg_sel   = mode1_q[1:0];
  wire trig_raw = (trg_sel == TRG_EVENT)    ? trig_edge[0] :     // RULE18
                  (trg_sel == TRG_CALENDAR) ? trig_edge[1] :
                  (trg_sel == TRG_INTERVAL) ? trig_edge[2] : 1'b0;
  // Low_power_autonomous_mode from stop mode only in one-shot form; others wait for wake-up
  wire stop_ok  = ~stop_mode | (oneshot_q & snz_wait_q);         // RULE13
  wire trig_go  = trig_raw & enable_q & stop_ok &                // RULE11
                  ~(woke_q & snz_wait_q);                         // RULE22
  wire snz_go   = stop_mode & snz_wait_q & oneshot_q;            // RULE17

  // ==========================================================================
  // Range check on the upper result bits
  wire [LIM_W-1:0] cmp_val = conv_data[RES_W-1 -: LIM_W];
  wire in_range = (cmp_val >= llim_q) && (cmp_val <= ulim_q);
  wire range_ok = rck_q ? ~in_range : in_range;
  wire last     = ~scan_q | (slot_q == SLOT_W'(SCAN_N - 1));
  wire restart  = trig_go | wr_ch | start1;
  wire in_conv  = (state_q == ST_CONV);
  wire store    = in_conv & en_now & ~start0 & ~restart & conv_done &
                  range_ok;                                       // RULE12

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_d   = state_q;
    start_d   = start_q;
    slot_d    = slot_q;
    cnt_d     = cnt_q;
    clkreq_d  = clkreq_q;
    snz_act_d = snz_act_q;
    hit_d     = hit_q;
    woke_d    = woke_q;
    cstart_d  = 1'b0;
    cabort_d  = 1'b0;
    wake_d    = 1'b0;
    if (woke_q && !snz_now) begin
      woke_d   = 1'b0;
      clkreq_d = 1'b0;
    end
    case (state_q)
      ST_STOP: begin
        if (wr_m0 && new_en)
          state_d = ST_WAIT;                                      // RULE1
      end
      ST_WAIT: begin
        if (!en_now) begin
          state_d = ST_STOP;
        end else if (trig_go && snz_go) begin
          state_d   = ST_STAB;                                    // RULE17
          clkreq_d  = 1'b1;
          snz_act_d = 1'b1;
          hit_d     = 1'b0;
          cnt_d     = CNT_W'(STAB_CYCLES - 1);
        end else if (trig_go) begin
          state_d  = ST_CONV;                                     // RULE2
          start_d  = 1'b1;
          slot_d   = '0;
          cstart_d = 1'b1;
        end
      end
      ST_STAB: begin
        if (!en_now) begin
          state_d   = ST_STOP;
          clkreq_d  = 1'b0;
          snz_act_d = 1'b0;
        end else if (cnt_q == '0) begin
          state_d  = ST_CONV;
          start_d  = 1'b1;
          slot_d   = '0;
          cstart_d = 1'b1;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_CONV: begin
        if (!en_now || start0) begin
          state_d   = en_now ? ST_WAIT : ST_STOP;                 // RULE10
          start_d   = 1'b0;
          cabort_d  = 1'b1;
          clkreq_d  = clkreq_q & woke_q;
          snz_act_d = 1'b0;
        end else if (restart) begin
          cabort_d = 1'b1;                                        // RULE7 RULE8
          cstart_d = 1'b1;                                        // RULE9
          slot_d   = '0;
        end else if (conv_done) begin
          if (store && snz_act_q)
            hit_d = 1'b1;
          if (!last) begin
            slot_d   = slot_q + SLOT_W'(1);                       // RULE3
            cstart_d = 1'b1;
          end else if (!oneshot_q) begin
            slot_d   = '0;                                        // RULE5
            cstart_d = 1'b1;
          end else begin
            state_d = ST_WAIT;                                    // RULE6
            start_d = 1'b0;
            slot_d  = '0;
            if (snz_act_q) begin
              snz_act_d = 1'b0;
              if (hit_q || store) begin
                woke_d = 1'b1;                                    // RULE19 RULE20
                wake_d = 1'b1;
              end else begin
                clkreq_d = 1'b0;                                  // RULE21
              end
            end
          end
        end
      end
      default: state_d = ST_STOP;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q   <= 1'b0;
      scan_q     <= 1'b0;
      oneshot_q  <= 1'b0;
      mode1_q    <= MODE1_RST;
      snz_wait_q <= 1'b0;
      rck_q      <= 1'b0;
      chsel_q    <= '0;
      ulim_q     <= ULIM_RST;
      llim_q     <= LLIM_RST;
      prdata_q   <= 32'h0;
    end else begin
      enable_q   <= en_now;
      scan_q     <= scan_now;
      oneshot_q  <= oneshot_now;
      snz_wait_q <= snz_now;
      chsel_q    <= base_now;
      if (wr && sel_m1)
        mode1_q <= pwdata[MODE_W-1:0];
      if (wr_m2)
        rck_q <= pwdata[M2_RCK];
      if (wr && sel_ul)
        ulim_q <= pwdata[LIM_W-1:0];
      if (wr && sel_ll)
        llim_q <= pwdata[LIM_W-1:0];
      if (psel && !penable)
        prdata_q <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_STOP;
      start_q     <= 1'b0;
      slot_q      <= '0;
      cnt_q       <= '0;
      clkreq_q    <= 1'b0;
      snz_act_q   <= 1'b0;
      hit_q       <= 1'b0;
      woke_q      <= 1'b0;
      cstart_q    <= 1'b0;
      cabort_q    <= 1'b0;
      wake_q      <= 1'b0;
      trig_prev_q <= '0;
    end else begin
      state_q     <= state_d;
      start_q     <= start_d;
      slot_q      <= slot_d;
      cnt_q       <= cnt_d;
      clkreq_q    <= clkreq_d;
      snz_act_q   <= snz_act_d;
      hit_q       <= hit_d;
      woke_q      <= woke_d;
      cstart_q    <= cstart_d;
      cabort_q    <= cabort_d;
      wake_q      <= wake_d;
      trig_prev_q <= trig_sync;
    end
  end

  // Result write loses to a same-cycle mode register 0 or channel write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      irq_q    <= 1'b0;
      chan_q   <= '0;
    end else begin
      irq_q <= store;                                             // RULE4
      if (store)
        result_q <= conv_data;
      if (cstart_d)
        chan_q <= base_now + CH_W'(slot_d);
    end
  end

  assign conv_start         = cstart_q;
  assign conv_abort         = cabort_q;
  assign conv_channel       = chan_q;
  assign conversion_end_irq = irq_q;
  assign osc_clk_req        = clkreq_q;
  assign low_power_autonomous_mode_wakeup      = wake_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire done_go = in_conv & conv_done & en_now & ~start0 & ~restart;

  ignore_trig_a: assert property (!en_now |=> !conv_start) // RULE11
    else $error("conversion started while disabled");
  enable_wait_a: assert property (state_q == ST_STOP && wr_m0 && new_en
    |=> state_q == ST_WAIT && !conv_start) // RULE1
    else $error("enable did not enter standby");
  trig_start_a: assert property (state_q == ST_WAIT && en_now && trig_go &&
    !snz_go |=> in_conv && start_q && slot_q == '0 && conv_start) // RULE2
    else $error("trigger did not start scan");
  slot_order_a: assert property (done_go && !last
    |=> slot_q == $past(slot_q) + SLOT_W'(1) && conv_start) // RULE3
    else $error("scan slot did not advance");
  store_irq_a: assert property (store
    |=> conversion_end_irq && result_q == $past(conv_data)) // RULE4
    else $error("result not stored with interrupt");
  reject_a: assert property (done_go && !range_ok
    |=> !conversion_end_irq && $stable(result_q)) // RULE12
    else $error("rejected result was stored");
  seq_wrap_a: assert property (done_go && last && !oneshot_q
    |=> in_conv && slot_q == '0 && conv_start) // RULE5
    else $error("sequential scan did not wrap");
  oneshot_end_a: assert property (done_go && last && oneshot_q
    |=> !start_q && state_q == ST_WAIT) // RULE6
    else $error("one-shot did not clear start");
  trig_restart_a: assert property (in_conv && en_now && !start0 && trig_go
    |=> conv_abort && conv_start && slot_q == '0) // RULE7
    else $error("trigger did not restart scan");
  chsel_restart_a: assert property (in_conv && en_now && !start0 && wr_ch
    |=> conv_abort && conv_channel == $past(pwdata[CH_W-1:0])) // RULE8
    else $error("channel write did not restart");
  start_restart_a: assert property (in_conv && start1 && new_en
    |=> conv_abort && conv_start && start_q) // RULE9
    else $error("start write did not restart");
  stop_abort_a: assert property (in_conv && start0 && new_en
    |=> conv_abort && state_q == ST_WAIT && !start_q) // RULE10
    else $error("start clear did not abort");
  stab_wait_a: assert property (state_q == ST_WAIT && en_now && trig_go &&
    snz_go |=> osc_clk_req && !conv_start ##[1:200] conv_start) // RULE17
    else $error("stabilization wait not honoured");
  no_hit_drop_a: assert property (done_go && last && oneshot_q &&
    snz_act_q && !hit_q && !store |=> !osc_clk_req) // RULE21
    else $error("clock request kept without interrupt");
  hit_wake_a: assert property (done_go && last && oneshot_q && snz_act_q &&
    (hit_q || store) |=> osc_clk_req && low_power_autonomous_mode_wakeup) // RULE19
    else $error("low_power_autonomous_mode did not wake");

  scan_pass_c: cover property (done_go && last && scan_q);
  low_power_autonomous_mode_wake_c: cover property (low_power_autonomous_mode_wakeup);
  low_power_autonomous_mode_drop_c: cover property ($fell(osc_clk_req));
  restart_c: cover property (conv_abort && conv_start);

endmodule

//--- verification/ahs_core_model.sv
// Behavioural conversion core that answers the sequencer's start and abort
module ahs_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [3:0] lat,
  input  wire logic [9:0] din,
  output logic            conv_done,
  output logic      [9:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic [3:0] cnt;
  // ==========================================================================
  // Core
  // Data toggles outside the done cycle so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy <= 1'b1;
        cnt  <= lat;
      end else if (conv_abort) begin
        busy <= 1'b0;
      end else if (busy && cnt == 4'h0) begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= din;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

//--- verification/adc_hw_trigger_low_power_autonomous_mode_ctrl_tb_top.sv
// Self-checking bench for the trigger and low_power_autonomous_mode sequencer
module adc_hw_trigger_low_power_autonomous_mode_ctrl_tb_top;
  import ahs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STB = 6;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode, pready;
  logic        pslverr, conv_start, conv_abort, conv_done, irq, osc;
  logic        wake, inv, pend, pok, err;
  logic [2:0]  trg;
  logic [3:0]  lat;
  logic [4:0]  conv_channel, base;
  logic [7:0]  paddr, ulim, llim;
  logic [9:0]  conv_data, din, pdat, lastres;
  logic [31:0] pwdata, prdata, rv, seed;
  int          n_errors, n_checks, nst, nab, nwk, slot, cyc, s, sa, w, c;

  ahs_ctrl #(.SCAN_N(4), .STAB_CYCLES(STB)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_event_in(trg[0]),
    .trig_calendar_in(trg[1]), .trig_interval_in(trg[2]),
    .stop_mode(stop_mode), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_data(conv_data),
    .conversion_end_irq(irq), .osc_clk_req(osc), .low_power_autonomous_mode_wakeup(wake));

  ahs_core_model core (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_abort(conv_abort), .lat(lat),
    .din(din), .conv_done(conv_done), .conv_data(conv_data));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic ok(input logic [9:0] d);
    return ((d[9:2] >= llim) && (d[9:2] <= ulim)) ^ inv;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Model copies of limits and channel base follow the write's own edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv  = prdata;
    err = pslverr;
    if (wr && a == OFF_CHSEL) base <= d[4:0];
    if (wr && a == OFF_ULIM) ulim <= d[7:0];
    if (wr && a == OFF_LLIM) llim <= d[7:0];
    if (wr && a == OFF_MODE2) inv <= d[M2_RCK];
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask

  task automatic trig(input int k);
    trg[k] <= 1'b1;
    repeat (3) @(posedge pclk);
    trg[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic wst(input int n);
    repeat (600) if (nst < n) @(posedge pclk);
  endtask

  // ==========================================================================
  // Clock, random core stimulus and result monitor
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    seed = xs(seed);
    din <= seed[9:0];
    lat <= {1'b0, seed[12:10]} + 4'h5;
  end

  // Monitor samples mid-cycle, where the design's outputs have settled
  always @(negedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish();
    end
    if (presetn) begin
      if (!(pend && conv_abort)) chk(32'(irq), 32'(pend && pok));
      if (pend && pok && !conv_abort) lastres = pdat;
      pend = conv_done;
      pok  = ok(conv_data);
      pdat = conv_data;
      if (conv_abort) begin
        nab++;
        slot = 0;
      end
      if (conv_start) begin
        chk(32'(conv_channel), 32'(5'(base + slot)));
        slot = (slot + 1) % 4;
        nst++;
      end
      nwk += 32'(wake);
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, stop_mode, inv, pend, pok} = '0;
    {paddr, pwdata, trg, din, lat, base, llim} = '0;
    {n_errors, n_checks, nst, nab, nwk, slot, cyc} = '0;
    ulim = 8'hFF;
    lastres = 10'h000;
    seed = 32'h56;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk(OFF_ULIM, 32'hFF);
    rdchk(OFF_LLIM, 32'h0);
    rdchk(OFF_MODE1, 32'h0);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(8'h20, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, OFF_MODE1, 32'h1);
    s = nst;
    trig(0);
    chk(nst, s);
    // Base near the top checks the channel wrap
    apb(1'b1, OFF_CHSEL, 32'h1E);
    apb(1'b1, OFF_MODE0, 32'h3);
    repeat (20) @(posedge pclk);
    chk(nst, s);
    rdchk(OFF_STATUS, 32'h1);
    trig(0);
    apb(1'b0, OFF_MODE0, 32'h0);
    chk(32'(rv[M0_START]), 32'h1);
    wst(s + 6);
    chk(32'(nst >= s + 6), 32'h1);
    sa = nab;
    trig(0);
    apb(1'b1, OFF_CHSEL, 32'h5);
    apb(1'b1, OFF_MODE0, 32'h83);
    repeat (3) @(posedge pclk);
    chk(nab, sa + 3);
    apb(1'b1, OFF_MODE0, 32'h3);
    repeat (2) @(posedge pclk);
    s = nst;
    repeat (30) @(posedge pclk);
    chk(nst, s);
    chk(nab, sa + 4);
    rdchk(OFF_STATUS, 32'h1);
    apb(1'b1, OFF_MODE0, 32'h0);
    for (int k = 1; k <= 3; k++) begin
      // Last pass inverts the check so every result is rejected
      if (k == 3) apb(1'b1, OFF_MODE2, 32'h8);
      apb(1'b1, OFF_MODE1, 32'(k));
      apb(1'b1, OFF_MODE0, 32'h7);
      s = nst;
      trig(k % 3);
      chk(nst, s);
      trig(k - 1);
      wst(s + 4);
      repeat (40) @(posedge pclk);
      chk(nst, s + 4);
      rdchk(OFF_MODE0, 32'h7);
      rdchk(OFF_RESULT, 32'(lastres));
      apb(1'b1, OFF_MODE0, 32'h0);
    end
    apb(1'b1, OFF_MODE2, 32'h4);
    apb(1'b1, OFF_MODE1, 32'hE1);
    apb(1'b1, OFF_LLIM, 32'hFF);
    apb(1'b1, OFF_ULIM, 32'h0);
    apb(1'b1, OFF_MODE0, 32'h3);
    stop_mode <= 1'b1;
    s = nst;
    trig(0);
    chk(nst, s);
    apb(1'b1, OFF_MODE0, 32'h7);
    // First pass rejects every result, second passes every result
    for (int p = 0; p < 2; p++) begin
      s = nst;
      w = nwk;
      trg[0] <= 1'b1;
      c = 0;
      while (osc !== 1'b1 && c < 50) begin
        @(posedge pclk);
        c++;
      end
      c = 0;
      while (nst == s && c < 50) begin
        @(posedge pclk);
        c++;
      end
      trg[0] <= 1'b0;
      chk(32'(c >= STB - 1 && c <= STB + 3), 32'h1);
      wst(s + 4);
      repeat (20) @(posedge pclk);
      chk(32'(osc), 32'(p));
      chk(nwk, w + p);
      apb(1'b1, OFF_MODE2, 32'hC);
    end
    s = nst;
    trig(0);
    chk(nst, s);
    apb(1'b1, OFF_MODE2, 32'h8);
    repeat (2) @(posedge pclk);
    chk(32'(osc), 32'h0);
    tally_and_finish();
  end
endmodule
